// ===== sps_consts.vh
// stepper phase sequencer constants, register map and field layout
// Contract
// - full step: four phases per clock cycle
// - full step: both coils always carry current; an odd phase left by half step drives one coil until the next step
// - half step: eight phases per clock cycle
// - half phases A,C,E,G match full polarities
// - half phases B,D,F,H drive one coil
// - impedance select matters only half step, idle coil
// - impedance low: idle coil drivers all off
// - impedance high: idle coil high sides on
// - bias below 5 uA: phase A, outputs off
// - set condition drives home flag low
// - set condition ignores step clock and controls
// - release resumes in phase A drive
// - after release, steps and controls act again
// - reduced bias lowers current, keeps phase
// - advance on each rising step clock edge
// - home flag low whenever phase A
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH

// register byte offsets
`define SPS_ADDR_CTRL 8'h00
`define SPS_ADDR_BIAS 8'h04
`define SPS_ADDR_STEP 8'h08
`define SPS_ADDR_STATUS 8'h0c
`define SPS_ADDR_POS 8'h10

// control register fields
`define SPS_CTRL_HALF 0
`define SPS_CTRL_DIR 1
`define SPS_CTRL_IDLE_HI 2
`define SPS_CTRL_W 3
`define SPS_CTRL_RST 3'h0

// bias register: drive current in microamps, below 5 means set
`define SPS_BIAS_RST 10'h000
`define SPS_SET_LIMIT_UA 10'h005

// step register: writing this bit as one issues a step
`define SPS_STEP_GO 0

// status register fields
`define SPS_ST_PHASE_LO 0
`define SPS_ST_SET 3
`define SPS_ST_HOME 4
`define SPS_ST_SET_SEEN 5
`define SPS_ST_MISSED 6
`define SPS_ST_DRV_LO 8

// phase index and step sizes, in half-step units
`define SPS_PHASE_A 3'h0
`define SPS_ADV_HALF 3'h1
`define SPS_ADV_FULL 3'h2
`define SPS_COIL2_OFS 3'h6

// coil polarity codes
`define SPS_COIL_OFF 2'h0
`define SPS_COIL_POS 2'h1
`define SPS_COIL_NEG 2'h2

`endif

// ===== sps_phase_decode.v
// phase index to bridge driver decode for both coils
`timescale 1ns/1ps
`include "sps_consts.vh"

module sps_phase_decode (
   // phase position and mode
   input wire [2:0] phase,
   input wire half_step,
   input wire idle_hi,
   // driver enables: {c2b_ls,c2b_hs,c2a_ls,c2a_hs,c1b_ls,c1b_hs,c1a_ls,c1a_hs}
   output reg [7:0] drv
);

   // polarity of coil one at a half-step index; coil two is the same
   // pattern rotated, so one table serves both
   function [1:0] coil_pol;
      input [2:0] idx;
      begin
         case (idx)
            3'h0, 3'h6, 3'h7: coil_pol = `SPS_COIL_POS;
            3'h2, 3'h3, 3'h4: coil_pol = `SPS_COIL_NEG;
            default: coil_pol = `SPS_COIL_OFF;
         endcase
      end
   endfunction

   // one full bridge from its polarity
   function [3:0] bridge;
      input [1:0] pol;
      input idle_high;
      begin
         if (pol == `SPS_COIL_POS) begin
            bridge = 4'h9; // a high side, b low side
         end else if (pol == `SPS_COIL_NEG) begin
            bridge = 4'h6; // b high side, a low side
         end else if (idle_high) begin
            bridge = 4'h5;
         end else begin
            bridge = 4'h0;
         end
      end
   endfunction

   reg [2:0] idx2;
   reg idle_high;

   // even indices are the two-coil phases, odd ones the one-coil phases
   always @* begin
      idx2 = phase + `SPS_COIL2_OFS;
      idle_high = half_step & idle_hi;
      drv = {bridge(coil_pol(idx2), idle_high), bridge(coil_pol(phase), idle_high)};
   end

endmodule

// ===== sps_sequencer.v
// stepper phase sequencer with apb register access and bridge driver outputs
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "sps_consts.vh"

module sps_sequencer #(
   parameter ADDR_W = 8,
   parameter BIAS_W = 10,
   parameter POS_W = 16
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // step clock and open bias pin from the controller
   input wire step_clk,
   input wire bias_open,
   // coil one bridge drivers
   output reg coil1_out_a_hs,
   output reg coil1_out_a_ls,
   output reg coil1_out_b_hs,
   output reg coil1_out_b_ls,
   // coil two bridge drivers
   output reg coil2_out_a_hs,
   output reg coil2_out_a_ls,
   output reg coil2_out_b_hs,
   output reg coil2_out_b_ls,
   // drive current setting in microamps
   output reg [BIAS_W-1:0] drive_current_ua,
   // open-drain home phase indicator, low when active
   input wire home_phase_flag_n_in,
   output wire home_phase_flag_n_out,
   output reg home_phase_flag_n_oe
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------

   reg [`SPS_CTRL_W-1:0] ctrl;
   reg [BIAS_W-1:0] bias;
   reg [2:0] phase;
   reg [POS_W-1:0] position;
   reg step_prev;
   reg set_seen;
   reg step_missed;
   reg rd_err;
   reg [31:0] rd_word;

   wire step_size_select;
   wire direction_select;
   wire idle_coil_impedance_select;
   wire set_active;
   wire step_edge;
   wire step_wr;
   wire step_req;
   wire step_take;
   wire [7:0] dec_drv;
   wire [7:0] drv_now;

   reg [2:0] adv;
   reg [2:0] next_phase;
   reg [POS_W-1:0] next_position;

   assign step_size_select = ctrl[`SPS_CTRL_HALF];
   assign direction_select = ctrl[`SPS_CTRL_DIR];
   assign idle_coil_impedance_select = ctrl[`SPS_CTRL_IDLE_HI];

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------

   // address decode shared by read and write paths
   function [2:0] reg_sel;
      input [ADDR_W-1:0] addr;
      begin
         if (addr == `SPS_ADDR_CTRL) begin
            reg_sel = 3'h1;
         end else if (addr == `SPS_ADDR_BIAS) begin
            reg_sel = 3'h2;
         end else if (addr == `SPS_ADDR_STEP) begin
            reg_sel = 3'h3;
         end else if (addr == `SPS_ADDR_STATUS) begin
            reg_sel = 3'h4;
         end else if (addr == `SPS_ADDR_POS) begin
            reg_sel = 3'h5;
         end else begin
            reg_sel = 3'h0;
         end
      end
   endfunction

   wire setup_ph;
   wire access_ph;
   wire wr_take;
   wire [2:0] sel_now;

   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign sel_now = reg_sel(paddr);
   assign wr_take = access_ph & pwrite & ~rd_err;
   // zero wait states: every access phase completes at once
   assign pready = 1'b1;

   // ------------------------------------------------------------
   // set condition and step detection
   // ------------------------------------------------------------

   // set while the bias pin is open or the bias setting is under the limit
   assign set_active = bias_open | (bias < `SPS_SET_LIMIT_UA);

   // rising edge of the step clock pin, or a step register write
   assign step_edge = step_clk & ~step_prev;
   assign step_wr = wr_take & (sel_now == 3'h3) & pstrb[0] & pwdata[`SPS_STEP_GO];
   assign step_req = step_edge | step_wr;
   // no step is taken while the set condition holds
   assign step_take = step_req & ~set_active;

   // ------------------------------------------------------------
   // phase advance
   // ------------------------------------------------------------

   // full step from an odd position lands on the next even one,
   // so a mode change continues from where the phase stands
   always @* begin
      if (step_size_select) begin
         adv = `SPS_ADV_HALF;
      end else if (phase[0]) begin
         adv = `SPS_ADV_HALF;
      end else begin
         adv = `SPS_ADV_FULL;
      end
      if (direction_select) begin
         next_phase = phase - adv;
         next_position = position - {{(POS_W-3){1'b0}}, adv};
      end else begin
         next_phase = phase + adv;
         next_position = position + {{(POS_W-3){1'b0}}, adv};
      end
   end

   // phase register, held at phase a while set
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= `SPS_PHASE_A;
         position <= {POS_W{1'b0}};
      end else if (set_active) begin
         phase <= `SPS_PHASE_A;
      end else if (step_take) begin
         phase <= next_phase;
         position <= next_position;
      end
   end

   // step clock history, tracked even during set so release makes no edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_prev <= 1'b0;
      end else begin
         step_prev <= step_clk;
      end
   end

   // ------------------------------------------------------------
   // driver outputs
   // ------------------------------------------------------------

   sps_phase_decode u_decode (
      .phase(phase),
      .half_step(step_size_select),
      .idle_hi(idle_coil_impedance_select),
      .drv(dec_drv)
   );

   // all drivers off during set; release shows phase a drive
   assign drv_now = set_active ? 8'h00 : dec_drv;

   // registered bridge drivers and current setting
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coil1_out_a_hs <= 1'b0;
         coil1_out_a_ls <= 1'b0;
         coil1_out_b_hs <= 1'b0;
         coil1_out_b_ls <= 1'b0;
         coil2_out_a_hs <= 1'b0;
         coil2_out_a_ls <= 1'b0;
         coil2_out_b_hs <= 1'b0;
         coil2_out_b_ls <= 1'b0;
         drive_current_ua <= {BIAS_W{1'b0}};
      end else begin
         coil1_out_a_hs <= drv_now[0];
         coil1_out_a_ls <= drv_now[1];
         coil1_out_b_hs <= drv_now[2];
         coil1_out_b_ls <= drv_now[3];
         coil2_out_a_hs <= drv_now[4];
         coil2_out_a_ls <= drv_now[5];
         coil2_out_b_hs <= drv_now[6];
         coil2_out_b_ls <= drv_now[7];
         // reduced bias only scales the current
         drive_current_ua <= set_active ? {BIAS_W{1'b0}} : bias;
      end
   end

   // home flag pulls low while the phase is a, set included
   assign home_phase_flag_n_out = 1'b0;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         home_phase_flag_n_oe <= 1'b1;
      end else begin
         home_phase_flag_n_oe <= set_active | (phase == `SPS_PHASE_A);
      end
   end

   // ------------------------------------------------------------
   // control and bias registers
   // ------------------------------------------------------------

   // writes are stored at any time; direction acts on the next step, mode bits and bias reach the drivers at once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SPS_CTRL_RST;
         bias <= `SPS_BIAS_RST;
      end else if (wr_take) begin
         if ((sel_now == 3'h1) && pstrb[0]) begin
            ctrl <= pwdata[`SPS_CTRL_W-1:0];
         end
         if ((sel_now == 3'h2) && pstrb[0]) begin
            bias[7:0] <= pwdata[7:0];
         end
         if ((sel_now == 3'h2) && pstrb[1]) begin
            bias[BIAS_W-1:8] <= pwdata[BIAS_W-1:8];
         end
      end
   end

   // ------------------------------------------------------------
   // sticky status bits, write one to clear, a new event wins
   // ------------------------------------------------------------

   wire st_clr;

   assign st_clr = wr_take & (sel_now == 3'h4) & pstrb[0];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_seen <= 1'b0;
         step_missed <= 1'b0;
      end else begin
         if (set_active) begin
            set_seen <= 1'b1;
         end else if (st_clr && pwdata[`SPS_ST_SET_SEEN]) begin
            set_seen <= 1'b0;
         end
         if (step_req && set_active) begin
            step_missed <= 1'b1;
         end else if (st_clr && pwdata[`SPS_ST_MISSED]) begin
            step_missed <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------

   // read word for the addressed register
   always @* begin
      rd_word = 32'h0000_0000;
      if (sel_now == 3'h1) begin
         rd_word[`SPS_CTRL_W-1:0] = ctrl;
      end else if (sel_now == 3'h2) begin
         rd_word[BIAS_W-1:0] = bias;
      end else if (sel_now == 3'h4) begin
         rd_word[`SPS_ST_PHASE_LO+2:`SPS_ST_PHASE_LO] = phase;
         rd_word[`SPS_ST_SET] = set_active;
         rd_word[`SPS_ST_HOME] = ~home_phase_flag_n_in;
         rd_word[`SPS_ST_SET_SEEN] = set_seen;
         rd_word[`SPS_ST_MISSED] = step_missed;
         rd_word[`SPS_ST_DRV_LO+7:`SPS_ST_DRV_LO] = drv_now;
      end else if (sel_now == 3'h5) begin
         rd_word[POS_W-1:0] = position;
      end
   end

   // data and error captured in the setup cycle, shown in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         rd_err <= 1'b0;
      end else if (setup_ph) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
         rd_err <= (sel_now == 3'h0);
      end
   end

   // error answer for unmapped addresses only in the access cycle
   always @* begin
      pslverr = access_ph & rd_err;
   end

endmodule

// ===== sps_seq_assertions.sv
// concurrent checks on the sequencer bridge outputs and home flag
`timescale 1ns/1ps
module sps_seq_assertions #(
   parameter ADDR_W = 8,
   parameter BIAS_W = 10
) (
   // clock, reset and apb writes
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   // controller side
   input wire step_clk,
   input wire bias_open,
   // bridge drivers and home flag
   input wire coil1_out_a_hs,
   input wire coil1_out_a_ls,
   input wire coil1_out_b_hs,
   input wire coil1_out_b_ls,
   input wire coil2_out_a_hs,
   input wire coil2_out_a_ls,
   input wire coil2_out_b_hs,
   input wire coil2_out_b_ls,
   input wire home_phase_flag_n_oe
);
   // ------------------------------------------------------------
   // shadow of mode and bias registers
   // ------------------------------------------------------------
   reg [2:0] ctrl_w;
   reg [BIAS_W-1:0] bias_w;
   wire wr = psel & penable & pwrite;
   wire set_c = bias_open | (bias_w < 16'h0005);
   wire [7:0] drv = {coil2_out_b_ls, coil2_out_b_hs, coil2_out_a_ls, coil2_out_a_hs,
      coil1_out_b_ls, coil1_out_b_hs, coil1_out_a_ls, coil1_out_a_hs};
   wire c1_on = drv[3:0] == 4'h9 || drv[3:0] == 4'h6;
   wire c2_on = drv[7:4] == 4'h9 || drv[7:4] == 4'h6;
   wire two_on = c1_on & c2_on;
   // track writes at the access edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_w <= 3'h0;
         bias_w <= {BIAS_W{1'b0}};
      end else if (wr && paddr == 8'h00) begin
         if (pstrb[0]) begin
            ctrl_w <= pwdata[2:0];
         end
      end else if (wr && paddr == 8'h04) begin
         if (pstrb[0]) begin
            bias_w[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            bias_w[BIAS_W-1:8] <= pwdata[BIAS_W-1:8];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a step taken with the set condition clear for two samples
   sequence s_step;
      $rose(step_clk) && !set_c && !$past(set_c);
   endsequence
   sequence s_half;
      s_step ##0 ctrl_w[0];
   endsequence
   property p_set_off; set_c |=> drv == 8'h00; endproperty
   property p_set_home; set_c |=> home_phase_flag_n_oe; endproperty
   property p_release; $fell(set_c) && !$rose(step_clk) |=> drv == 8'h99; endproperty
   // drivers show the new phase two edges after the step edge
   property p_full; s_step ##0 !ctrl_w[0] |=> ##1 two_on; endproperty
   property p_half_alt; s_half |=> ##1 (two_on != $past(two_on)); endproperty
   property p_idle_lo;
      s_half ##0 !ctrl_w[2] |=> ##1 (two_on || (c1_on && drv[7:4] == 4'h0) ||
         (c2_on && drv[3:0] == 4'h0));
   endproperty
   property p_idle_hi;
      s_half ##0 ctrl_w[2] |=> ##1 (two_on || (c1_on && drv[7:4] == 4'h5) ||
         (c2_on && drv[3:0] == 4'h5));
   endproperty
   property p_home; home_phase_flag_n_oe == (drv == 8'h99 || drv == 8'h00); endproperty
   a_set_off: assert property (p_set_off) else $error("drivers on in set");
   a_set_home: assert property (p_set_home) else $error("home flag off in set");
   a_release: assert property (p_release) else $error("release not home");
   a_full: assert property (p_full) else $error("full step one coil");
   a_half_alt: assert property (p_half_alt) else $error("half no alternation");
   a_idle_lo: assert property (p_idle_lo) else $error("idle coil not off");
   a_idle_hi: assert property (p_idle_hi) else $error("idle coil not high");
   a_home: assert property (p_home) else $error("home flag wrong");
endmodule

// ===== sps_ctl_model.sv
// controller model: step clock, bias pin and pulled-up home flag line
`timescale 1ns/1ps
module sps_ctl_model (
   // clock
   input wire pclk,
   // controller outputs
   output reg step_clk,
   output reg bias_open,
   // open-drain home flag line
   input wire flag_oe,
   input wire flag_drv,
   output wire flag_line_n
);
   // pull-up unless the sequencer drives the line
   assign flag_line_n = flag_oe ? flag_drv : 1'b1;
   // bias pin held open through power-up
   initial begin
      step_clk = 1'b0;
      bias_open = 1'b1;
   end
   // one step pulse, high for hold cycles, then low for one sample at least
   task pulse(input integer hold);
      begin
         @(posedge pclk);
         step_clk <= 1'b1;
         repeat (hold) @(posedge pclk);
         step_clk <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // open or close the bias pin
   task bias(input v);
      begin
         @(posedge pclk);
         bias_open <= v;
      end
   endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the stepper phase sequencer
`timescale 1ns/1ps
module tb_top;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   wire pready, pslverr, step_clk, bias_open, flag_n, flag_oe, flag_out;
   reg [3:0] strb = 4'hf;
   reg via = 1'b0;
   reg [15:0] pos = 16'h0;
   wire [31:0] prdata;
   wire [9:0] cur;
   wire [7:0] dv;
   integer err_count = 0;
   integer checked = 0;
   reg [2:0] ph = 3'h0;
   reg half = 1'b0;
   reg ih = 1'b0;
   reg rev = 1'b0;
   reg er = 1'b0;
   reg [31:0] rd = 32'h0;
   // ------------------------------------------------------------
   // clock, design and controller
   // ------------------------------------------------------------
   always #4 pclk = ~pclk;
   sps_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .step_clk(step_clk), .bias_open(bias_open),
      .coil1_out_a_hs(dv[0]), .coil1_out_a_ls(dv[1]), .coil1_out_b_hs(dv[2]),
      .coil1_out_b_ls(dv[3]), .coil2_out_a_hs(dv[4]), .coil2_out_a_ls(dv[5]),
      .coil2_out_b_hs(dv[6]), .coil2_out_b_ls(dv[7]), .drive_current_ua(cur),
      .home_phase_flag_n_in(flag_n), .home_phase_flag_n_out(flag_out),
      .home_phase_flag_n_oe(flag_oe));
   sps_ctl_model model (.pclk(pclk), .step_clk(step_clk), .bias_open(bias_open),
      .flag_oe(flag_oe), .flag_drv(flag_out), .flag_line_n(flag_n));
   // expected nibble {b_ls,b_hs,a_ls,a_hs}: 1 forward, 2 reverse, 0 idle
   function [3:0] nib(input [1:0] c);
      nib = c == 2'h1 ? 4'h9 : c == 2'h2 ? 4'h6 : (half && ih) ? 4'h5 : 4'h0;
   endfunction
   function [7:0] exp_drv(input [2:0] p);
      reg [15:0] c1, c2;
      begin
         c1 = 16'h52a1;
         c2 = 16'h2a15;
         exp_drv = {nib(c2[2*p +: 2]), nib(c1[2*p +: 2])};
      end
   endfunction
   task close_out;
      begin
         $display("checks %0d mismatches %0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [8*12-1:0] nm, input [31:0] exp, input [31:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // one apb transfer, held until pready is seen high
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n = n + 1;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n >= 20) begin
            err_count = err_count + 1;
            close_out;
         end
      end
   endtask
   task mode(input h, input r, input i);
      begin
         half = h;
         rev = r;
         ih = i;
         apb(1'b1, 8'h00, {29'h0, i, r, h});
      end
   endtask
   // compare phase, drivers and home flag against the expected phase
   task st(input [2:0] p);
      begin
         repeat (2) @(posedge pclk);
         apb(1'b0, 8'h0c, 32'h0);
         chk("phase", p, rd[2:0]);
         chk("status drv", exp_drv(p), rd[15:8]);
         chk("drv pins", exp_drv(p), dv);
         chk("home oe", p == 3'h0, flag_oe);
      end
   endtask
   task step;
      reg [2:0] d;
      begin
         if (via) begin
            apb(1'b1, 8'h08, 32'h1);
         end else begin
            model.pulse(1);
         end
         d = (half || ph[0]) ? 3'h1 : 3'h2;
         ph = rev ? ph - d : ph + d;
         pos = rev ? pos - d : pos + d;
         st(ph);
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      begin
         chk("drv reset", 8'h00, dv);
         apb(1'b0, 8'h0c, 32'h0);
         chk("set flags", 5'h18, rd[4:0]);
         apb(1'b0, 8'h00, 32'h0);
         chk("ctrl reset", 32'h0, rd);
         strb <= 4'h0;
         apb(1'b1, 8'h00, 32'h7);
         strb <= 4'hf;
         apb(1'b0, 8'h00, 32'h0);
         chk("ctrl strobe", 32'h0, rd);
         apb(1'b0, 8'h04, 32'h0);
         chk("bias reset", 32'h0, rd);
         apb(1'b0, 8'h20, 32'h0);
         chk("unmapped", 1'b1, er);
      end
   endtask
   task t_release;
      begin
         model.bias(1'b0);
         apb(1'b1, 8'h04, 32'h0ab);
         st(3'h0);
         chk("current", 10'h0ab, cur);
      end
   endtask
   task t_steps;
      begin
         mode(1'b0, 1'b0, 1'b0);
         repeat (4) step;
         mode(1'b0, 1'b1, 1'b0);
         repeat (4) step;
         mode(1'b1, 1'b0, 1'b0);
         repeat (8) step;
         mode(1'b1, 1'b1, 1'b1);
         repeat (8) step;
         mode(1'b1, 1'b0, 1'b1);
         step;
         mode(1'b0, 1'b0, 1'b1);
         st(ph);
         step;
         via = 1'b1;
         step;
         via = 1'b0;
         apb(1'b0, 8'h10, 32'h0);
         chk("position", {16'h0, pos}, rd);
      end
   endtask
   task t_set;
      begin
         model.bias(1'b1);
         repeat (2) model.pulse(1);
         chk("drv set", 8'h00, dv);
         chk("oe set", 1'b1, flag_oe);
         apb(1'b0, 8'h0c, 32'h0);
         chk("set status", 7'h78, rd[6:0]);
         apb(1'b1, 8'h0c, 32'h60);
         apb(1'b0, 8'h0c, 32'h0);
         chk("set wins", 2'h1, rd[6:5]);
         model.bias(1'b0);
         apb(1'b1, 8'h0c, 32'h60);
         apb(1'b0, 8'h0c, 32'h0);
         chk("sticky clr", 2'h0, rd[6:5]);
         ph = 3'h0;
         st(ph);
         step;
      end
   endtask
   task t_bias;
      begin
         apb(1'b1, 8'h04, 32'h04b);
         st(ph);
         chk("low current", 10'h04b, cur);
         apb(1'b1, 8'h04, 32'h005);
         st(ph);
         apb(1'b1, 8'h04, 32'h004);
         repeat (2) @(posedge pclk);
         chk("drv low bias", 8'h00, dv);
         apb(1'b1, 8'h04, 32'h0ab);
         ph = 3'h0;
         st(ph);
      end
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_release;
      t_steps;
      t_set;
      t_bias;
      close_out;
   end
endmodule
bind sps_sequencer sps_seq_assertions #(.ADDR_W(ADDR_W), .BIAS_W(BIAS_W)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .step_clk(step_clk), .bias_open(bias_open),
   .coil1_out_a_hs(coil1_out_a_hs), .coil1_out_a_ls(coil1_out_a_ls),
   .coil1_out_b_hs(coil1_out_b_hs), .coil1_out_b_ls(coil1_out_b_ls),
   .coil2_out_a_hs(coil2_out_a_hs), .coil2_out_a_ls(coil2_out_a_ls),
   .coil2_out_b_hs(coil2_out_b_hs), .coil2_out_b_ls(coil2_out_b_ls),
   .home_phase_flag_n_oe(home_phase_flag_n_oe));
